/* File: hw/uart_control_status.sv */
// serial port with control, status, loopback, break and divider-timeout interrupt
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - transmit needs enable, and low CTS when gated
// - ungated transmitter ignores CTS completely
// - receiver works only while enabled
// - parity enable adds one parity bit
// - parity select: zero even, one odd
// - break holds line low, aborts character
// - stop select: one or two stop bits
// - loopback routes transmit into receiver
// - status bit zero holds last marker bit
// - reading receive data clears marker flag
// - upper seven status bits read zero
// - disabled port: divider zero raises receive interrupt
// - enabled port: timeout field has no effect
// - nine-bit mode adds marker bit per character
module uart_control_status (
  input  wire logic                          clk_sys,  // system clock
  input  wire logic                          rstn,     // async reset, active low
  input  wire logic [uart_cs_pkg::ADDR_W-1:0] addr,    // register address
  input  wire logic [uart_cs_pkg::DATA_W-1:0] wdata,   // write data
  input  wire logic                          wr,       // write strobe
  input  wire logic                          rd,       // read strobe
  output logic      [uart_cs_pkg::DATA_W-1:0] rdata,   // read data, cycle after rd
  input  wire logic                          rxd,      // serial line in
  input  wire logic                          cts_n,    // clear to send, active low
  output logic                               txd,      // serial line out
  output logic                               irq       // level interrupt
);
  import uart_cs_pkg::*;

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  ctl_a_t            ctl_a_q;        // control a fields
  logic [7:0]        ctl_b_q;        // control b byte
  logic [EV_N-1:0]   ev_q;           // sticky events
  logic [EV_N-1:0]   mask_q;         // event mask
  logic [7:0]        div_lo_q;       // divisor low
  logic [7:0]        div_hi_q;       // divisor high
  logic [15:0]       div_cnt_q;      // down counter
  logic [7:0]        rdata_q;        // read data flop
  logic [2:0]        rx_sync_q;      // rx pin synchroniser
  logic [2:0]        cts_sync_q;     // cts pin synchroniser
  logic              rx_f_q;         // filtered rx pin
  logic              cts_f_q;        // filtered cts pin
  logic              txd_q;          // line output flop
  bit_state_t        tx_st_q;        // transmit state
  logic [3:0]        tx_ph_q;        // tick within bit
  logic [2:0]        tx_idx_q;       // data bit index
  logic              tx_stop2_q;     // second stop bit pending
  logic [7:0]        tx_sh_q;        // transmit shifter
  logic              tx_par_q;       // parity bit to send
  logic              tx_mark_q;      // marker bit to send
  logic [7:0]        tx_hold_q;      // pending character
  logic              tx_pend_q;      // character waiting
  bit_state_t        rx_st_q;        // receive state
  logic [3:0]        rx_ph_q;        // tick within bit
  logic [2:0]        rx_idx_q;       // data bit index
  logic [7:0]        rx_sh_q;        // receive shifter
  logic              rx_par_q;       // running parity
  logic              rx_mark_q;      // marker in flight
  logic              rx_perr_q;      // parity error in flight
  logic [7:0]        rx_data_q;      // received character
  logic              rx_valid_q;     // character available
  logic              last_marker_bit_rx_q; // last marker bit
  logic              err_par_q;      // last char parity error
  logic              err_frm_q;      // last char framing error

  // ----------------------------------------------------------------
  // decode and combinational helpers
  // ----------------------------------------------------------------
  wire        sel_data   = addr == OFF_DATA;
  wire        sel_stat_a = addr == OFF_STAT_A;
  wire        sel_ctl_a  = addr == OFF_CTL_A;
  wire        sel_ctl_b  = addr == OFF_CTL_B;
  wire        sel_stat_b = addr == OFF_STAT_B;
  wire        sel_irq_st = addr == OFF_IRQ_ST;
  wire        sel_irq_mk = addr == OFF_IRQ_MK;
  wire        sel_div_lo = addr == OFF_DIV_LO;
  wire        sel_div_hi = addr == OFF_DIV_HI;
  wire        rd_data    = rd && sel_data;           // consumes rx character
  wire [15:0] div_val    = {div_hi_q, div_lo_q};
  wire        tick       = div_cnt_q == 16'h0000;    // divider reached zero
  wire        port_en    = ctl_a_q.tx_on || ctl_a_q.rx_on;
  wire        nine_bit   = ctl_b_q[CB_NINE_BIT];
  // transmitter may send: enable, and cts low only when gated
  wire        tx_allow   = ctl_a_q.tx_on && (!ctl_a_q.clear_to_send_gate || !cts_f_q);
  wire        tx_start   = tx_st_q == B_IDLE && tx_pend_q && tx_allow && !ctl_a_q.force_break;
  wire        tx_bit_end = tick && tx_ph_q == TICK_LAST;
  wire        rx_sample  = tick && rx_ph_q == TICK_LAST;
  // divider timeout feeds the receive event only while the port is off
  wire        div_rx_ev  = tick && !port_en && ctl_b_q[CB_TIMEOUT_IRQ];

  // bit on the transmit side before break and loopback
  logic tx_bit;
  always_comb
  begin
    unique case (tx_st_q)
      B_IDLE:  tx_bit = 1'b1;
      B_START: tx_bit = 1'b0;
      B_DATA:  tx_bit = tx_sh_q[0];                  // lsb first
      B_MARK:  tx_bit = tx_mark_q;
      B_PAR:   tx_bit = tx_par_q;
      B_STOP:  tx_bit = 1'b1;
      default: tx_bit = 1'b1;
    endcase
  end
  wire tx_line = ctl_a_q.force_break ? 1'b0 : tx_bit;
  wire rx_line = ctl_a_q.loopback_on ? tx_line : rx_f_q;

  // end-of-character events
  wire tx_done = tx_st_q == B_STOP && tx_bit_end && !(ctl_a_q.two_stop && !tx_stop2_q);
  wire rx_done = rx_st_q == B_STOP && rx_sample && ctl_a_q.rx_on;
  wire rx_err  = rx_done && (rx_perr_q || !rx_line);
  wire [EV_N-1:0] ev_set = {rx_err, rx_done || div_rx_ev, tx_done};

  // read mux
  wire [7:0] stat_a = {4'h0, err_par_q, err_frm_q, rx_valid_q, tx_pend_q || tx_st_q != B_IDLE};
  wire [7:0] stat_b = {7'h00, last_marker_bit_rx_q};
  wire [7:0] rmux   = sel_data   ? rx_data_q :
                      sel_stat_a ? stat_a :
                      sel_ctl_a  ? ctl_a_q :
                      sel_ctl_b  ? ctl_b_q :
                      sel_stat_b ? stat_b :
                      sel_irq_st ? {5'h00, ev_q} :
                      sel_irq_mk ? {5'h00, mask_q} :
                      sel_div_lo ? div_lo_q :
                      sel_div_hi ? div_hi_q : 8'h00; // unmapped reads zero

  assign rdata = rdata_q;
  assign txd   = txd_q;
  assign irq   = |(ev_q & mask_q);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // software writes; read data captured for the next cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_a_q  <= CTL_A_RST;
      ctl_b_q  <= CTL_B_RST;
      mask_q   <= IRQ_RST[EV_N-1:0];
      div_lo_q <= DIV_LO_RST;
      div_hi_q <= DIV_HI_RST;
      rdata_q  <= 8'h00;
    end
    else
    begin
      if (wr && sel_ctl_a) ctl_a_q  <= wdata;
      if (wr && sel_ctl_b) ctl_b_q  <= wdata;
      if (wr && sel_irq_mk) mask_q  <= wdata[EV_N-1:0];
      if (wr && sel_div_lo) div_lo_q <= wdata;
      if (wr && sel_div_hi) div_hi_q <= wdata;
      rdata_q <= rd ? rmux : 8'h00;
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ev_q <= IRQ_RST[EV_N-1:0];
    else
      ev_q <= (ev_q & ~((wr && sel_irq_st) ? wdata[EV_N-1:0] : 3'h0)) | ev_set;
  end

  // ----------------------------------------------------------------
  // pin synchronisers and baud divider
  // ----------------------------------------------------------------
  // three stages; level taken once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_sync_q  <= 3'h7;
      cts_sync_q <= 3'h7;
      rx_f_q     <= 1'b1;
      cts_f_q    <= 1'b1;
    end
    else
    begin
      rx_sync_q  <= {rx_sync_q[1:0], rxd};
      cts_sync_q <= {cts_sync_q[1:0], cts_n};
      if (rx_sync_q[1] == rx_sync_q[2]) rx_f_q <= rx_sync_q[2];
      if (cts_sync_q[1] == cts_sync_q[2]) cts_f_q <= cts_sync_q[2];
    end
  end

  // divider counts down and reloads; zero is one tick
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      div_cnt_q <= 16'h0000;
    else
      div_cnt_q <= tick ? div_val - 16'h0001 : div_cnt_q - 16'h0001;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // holding register and framing sequence
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_st_q <= B_IDLE;
      tx_ph_q <= 4'h0;
      tx_idx_q <= 3'h0;
      tx_stop2_q <= 1'b0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_mark_q <= 1'b0;
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else
    begin
      txd_q <= ctl_a_q.loopback_on ? 1'b1 : tx_line;  // pin idles in loopback
      if (wr && sel_data)
      begin
        tx_hold_q <= wdata;
        tx_pend_q <= 1'b1;
      end
      tx_ph_q <= tick ? tx_ph_q + 4'h1 : tx_ph_q;
      if (ctl_a_q.force_break)
        tx_st_q <= B_IDLE;                            // abort character
      else if (tx_start)
      begin
        tx_st_q <= B_START;
        tx_ph_q <= 4'h0;
        tx_sh_q <= tx_hold_q;
        tx_pend_q <= wr && sel_data;
        tx_mark_q <= ctl_b_q[CB_TX_MARK];
        // parity covers data and marker
        tx_par_q <= ^tx_hold_q ^ (nine_bit & ctl_b_q[CB_TX_MARK]) ^ ctl_a_q.parity_odd;
      end
      else if (tx_bit_end)
      begin
        unique case (tx_st_q)
          B_START:
          begin
            tx_st_q  <= B_DATA;
            tx_idx_q <= 3'h0;
          end
          B_DATA:
          begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q == DATA_LAST)
              tx_st_q <= nine_bit ? B_MARK : ctl_a_q.parity_on ? B_PAR : B_STOP;
            tx_stop2_q <= 1'b0;
          end
          B_MARK:  tx_st_q <= ctl_a_q.parity_on ? B_PAR : B_STOP;
          B_PAR:   tx_st_q <= B_STOP;
          B_STOP:
          begin
            if (ctl_a_q.two_stop && !tx_stop2_q)
              tx_stop2_q <= 1'b1;                     // second stop bit
            else
              tx_st_q <= B_IDLE;
          end
          default: tx_st_q <= B_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // start detect, mid-bit sampling, result capture
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_st_q <= B_IDLE;
      rx_ph_q <= 4'h0;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_mark_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      last_marker_bit_rx_q <= 1'b0;
      err_par_q <= 1'b0;
      err_frm_q <= 1'b0;
    end
    else
    begin
      rx_ph_q <= tick ? rx_ph_q + 4'h1 : rx_ph_q;
      if (rd_data)
      begin
        rx_valid_q <= 1'b0;
        last_marker_bit_rx_q <= 1'b0;
      end
      if (!ctl_a_q.rx_on)
        rx_st_q <= B_IDLE;
      else
      begin
        unique case (rx_st_q)
          B_IDLE:
            if (!rx_line)
            begin
              rx_st_q <= B_START;
              rx_ph_q <= 4'h0;
            end
          B_START:
            if (tick && rx_ph_q == TICK_HALF)
            begin
              rx_st_q <= rx_line ? B_IDLE : B_DATA;   // false start rejected
              rx_ph_q <= 4'h0;
              rx_idx_q <= 3'h0;
              rx_par_q <= ctl_a_q.parity_odd;
              rx_mark_q <= 1'b0;
              rx_perr_q <= 1'b0;
            end
          B_DATA:
            if (rx_sample)
            begin
              rx_sh_q  <= {rx_line, rx_sh_q[7:1]};    // lsb first
              rx_par_q <= rx_par_q ^ rx_line;
              rx_idx_q <= rx_idx_q + 3'h1;
              if (rx_idx_q == DATA_LAST)
                rx_st_q <= nine_bit ? B_MARK : ctl_a_q.parity_on ? B_PAR : B_STOP;
            end
          B_MARK:
            if (rx_sample)
            begin
              rx_mark_q <= rx_line;
              rx_par_q  <= rx_par_q ^ rx_line;
              rx_st_q   <= ctl_a_q.parity_on ? B_PAR : B_STOP;
            end
          B_PAR:
            if (rx_sample)
            begin
              rx_perr_q <= rx_par_q ^ rx_line;
              rx_st_q   <= B_STOP;
            end
          B_STOP:
            if (rx_sample)
              rx_st_q <= B_IDLE;
          default: rx_st_q <= B_IDLE;
        endcase
      end
      if (rx_done)
      begin
        rx_data_q <= rx_sh_q;
        rx_valid_q <= 1'b1;                           // new character beats read clear
        last_marker_bit_rx_q <= rx_mark_q;
        err_par_q <= rx_perr_q;
        err_frm_q <= !rx_line;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_tx_gate;
    @(posedge clk_sys) disable iff (!rstn)
    (tx_st_q == B_START && $past(tx_st_q) == B_IDLE) |-> $past(tx_allow) && $past(ctl_a_q.tx_on);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit started without permission");

  property p_cts_ignored;
    @(posedge clk_sys) disable iff (!rstn)
    (tx_st_q == B_IDLE && tx_pend_q && ctl_a_q.tx_on && !ctl_a_q.clear_to_send_gate && !ctl_a_q.force_break)
      |=> tx_st_q == B_START;
  endproperty
  a_cts_ignored: assert property (p_cts_ignored) else $error("ungated transmitter did not start");

  property p_rx_off;
    @(posedge clk_sys) disable iff (!rstn)
    !ctl_a_q.rx_on |=> rx_st_q == B_IDLE && !$rose(rx_valid_q);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver active while disabled");

  property p_break_low;
    @(posedge clk_sys) disable iff (!rstn)
    (ctl_a_q.force_break && !ctl_a_q.loopback_on) |=> !txd_q && tx_st_q == B_IDLE;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break did not hold line low");

  property p_two_stop;
    @(posedge clk_sys) disable iff (!rstn)
    (tx_st_q == B_STOP && tx_bit_end && ctl_a_q.two_stop && !tx_stop2_q && !ctl_a_q.force_break)
      |=> tx_st_q == B_STOP && tx_stop2_q;
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("second stop bit missing");

  property p_loopback;
    @(posedge clk_sys) disable iff (!rstn)
    ctl_a_q.loopback_on |-> (rx_line == tx_line) ##1 txd_q;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback path wrong");

  property p_marker;
    @(posedge clk_sys) disable iff (!rstn)
    rx_done |=> last_marker_bit_rx_q == $past(rx_mark_q) && rx_valid_q;
  endproperty
  a_marker: assert property (p_marker) else $error("marker flag not captured");

  property p_marker_clr;
    @(posedge clk_sys) disable iff (!rstn)
    (rd_data && !rx_done) |=> !last_marker_bit_rx_q;
  endproperty
  a_marker_clr: assert property (p_marker_clr) else $error("data read left marker set");

  property p_stat_b_zero;
    @(posedge clk_sys) disable iff (!rstn)
    (rd && sel_stat_b) |=> rdata[7:1] == 7'h00 && rdata[0] == $past(last_marker_bit_rx_q);
  endproperty
  a_stat_b_zero: assert property (p_stat_b_zero) else $error("status b upper bits not zero");

  property p_div_irq;
    @(posedge clk_sys) disable iff (!rstn)
    (tick && ctl_b_q[CB_TIMEOUT_IRQ] && !port_en) |=> ev_q[EV_RX_DONE];
  endproperty
  a_div_irq: assert property (p_div_irq) else $error("divider timeout missed");

  property p_div_quiet;
    @(posedge clk_sys) disable iff (!rstn)
    (port_en && !rx_done && !ev_q[EV_RX_DONE]) |=> !ev_q[EV_RX_DONE];
  endproperty
  a_div_quiet: assert property (p_div_quiet) else $error("timeout fired while enabled");

  c_tx_char:  cover property (@(posedge clk_sys) disable iff (!rstn) tx_done);
  c_rx_char:  cover property (@(posedge clk_sys) disable iff (!rstn) rx_done && !rx_err);
  c_rx_err:   cover property (@(posedge clk_sys) disable iff (!rstn) rx_err);
  c_div_tick: cover property (@(posedge clk_sys) disable iff (!rstn) div_rx_ev);

endmodule

`default_nettype wire

/* File: hw/uart_cs_pkg.sv */
// constants, field layouts and state types of the serial port control and status block
package uart_cs_pkg;

  // ----------------------------------------------------------------
  // register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;               // byte address width
  localparam int unsigned DATA_W = 8;                // register width

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DATA   = 12'hF40;      // write: tx char, read: rx char
  localparam logic [11:0] OFF_STAT_A = 12'hF41;      // line status
  localparam logic [11:0] OFF_CTL_A  = 12'hF42;      // serial_control_a
  localparam logic [11:0] OFF_CTL_B  = 12'hF43;      // serial_control_b
  localparam logic [11:0] OFF_STAT_B = 12'hF44;      // serial_status_b
  localparam logic [11:0] OFF_IRQ_ST = 12'hF45;      // sticky events, write one to clear
  localparam logic [11:0] OFF_IRQ_MK = 12'hF46;      // event mask
  localparam logic [11:0] OFF_DIV_LO = 12'hF47;      // baud divisor low byte
  localparam logic [11:0] OFF_DIV_HI = 12'hF48;      // baud divisor high byte

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_A_RST  = 8'h00;
  localparam logic [7:0] CTL_B_RST  = 8'h00;
  localparam logic [7:0] IRQ_RST    = 8'h00;
  localparam logic [7:0] DIV_LO_RST = 8'h01;
  localparam logic [7:0] DIV_HI_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CB_TIMEOUT_IRQ = 6;        // divider_timeout_irq
  localparam int unsigned CB_NINE_BIT    = 5;        // nine_bit_mode_on
  localparam int unsigned CB_TX_MARK     = 3;        // marker bit to send
  localparam int unsigned EV_TX_DONE     = 0;        // event bits
  localparam int unsigned EV_RX_DONE     = 1;
  localparam int unsigned EV_RX_ERR      = 2;
  localparam int unsigned EV_N           = 3;

  // ----------------------------------------------------------------
  // bit timing: divider ticks per bit
  // ----------------------------------------------------------------
  localparam logic [3:0] TICK_LAST = 4'hF;           // sixteen ticks per bit
  localparam logic [3:0] TICK_HALF = 4'h7;           // middle of the start bit
  localparam logic [2:0] DATA_LAST = 3'h7;           // eight data bits

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic clear_to_send_gate;
    logic parity_on;
    logic parity_odd;
    logic force_break;
    logic two_stop;
    logic loopback_on;
  } ctl_a_t;

  typedef enum logic [2:0] {B_IDLE, B_START, B_DATA, B_MARK, B_PAR, B_STOP} bit_state_t;

endpackage

/* File: dv/uart_far_end.sv */
// far-end serial transceiver model facing the block's line pins
`timescale 1ns/1ps
`default_nettype none
module uart_far_end (
  input  wire logic clk_sys, // system clock, 16 clocks per bit
  input  wire logic txd,     // line from the block
  output logic      rxd      // line into the block
);
  logic [7:0] got_q;   // last character heard on txd
  int         got_cnt; // characters heard on txd
  initial rxd = 1'b1;  // line idles high
  // send one frame: start, n bits lsb first, then idle at stop level
  task automatic send(input logic [8:0] bits, input int n);
    rxd <= 1'b0; // start bit
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i]; // data lsb first, marker last
      repeat (16) @(posedge clk_sys);
    end
    rxd <= 1'b1; // stop bits
    repeat (40) @(posedge clk_sys);
  endtask
  // watcher: samples start and eight data bits at mid-bit
  initial
  begin
    got_cnt = 0;
    forever
    begin
      @(negedge txd);
      repeat (8) @(posedge clk_sys);
      if (txd === 1'b0)
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (16) @(posedge clk_sys);
          got_q[i] = txd; // lsb first
        end
        got_cnt++;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the serial port control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uart_cs_pkg::*;
  logic              clk_sys = 1'b0; // 25 MHz clock
  logic              rstn    = 1'b0; // reset, active low
  logic [ADDR_W-1:0] addr    = '0;   // register address
  logic [DATA_W-1:0] wdata   = '0;   // write data
  logic              wr      = 1'b0; // write strobe
  logic              rd      = 1'b0; // read strobe
  logic              cts_n   = 1'b1; // clear to send, active low
  logic [DATA_W-1:0] rdata;          // read data
  logic              txd;            // line out
  logic              rxd;            // line in
  logic              irq;            // interrupt
  int                fails = 0;      // mismatches
  int                cmp_count = 0;  // comparisons
  always #20 clk_sys = ~clk_sys;
  uart_control_status i_uart_control_status (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq));
  uart_far_end i_uart_far_end (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
  // compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one-cycle register write
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys); // idle edge keeps one strobe assignment per time step
  endtask
  // one-cycle read, data judged in the following cycle
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys); // rdata still holds the answer in this time step
    chk(name, exp, rdata);
  endtask
  // bounded wait for the far end to hear n characters
  task automatic wait_got(input int n);
    for (int i = 0; i < 800 && i_uart_far_end.got_cnt < n; i++)
      @(posedge clk_sys);
    if (i_uart_far_end.got_cnt < n)
    begin
      fails++;
      $display("ERROR got_cnt expected %0d seen %0d", n, i_uart_far_end.got_cnt);
    end
  endtask
  // reset values, read-only and unmapped places
  task automatic t_regs();
    rd_chk("ctl_a", OFF_CTL_A, CTL_A_RST);
    rd_chk("ctl_b", OFF_CTL_B, CTL_B_RST);
    wr_reg(OFF_STAT_B, 8'hFF);
    rd_chk("stat_b", OFF_STAT_B, 8'h00);
    wr_reg(12'hF4F, 8'hFF);
    rd_chk("unmapped", 12'hF4F, 8'h00);
  endtask
  // gated transmitter waits for cts, ungated one ignores it
  task automatic t_tx();
    wr_reg(OFF_CTL_A, 8'hA0);
    wr_reg(OFF_DATA, 8'h5A);
    repeat (300) @(posedge clk_sys);
    chk("held", 8'h00, 8'(i_uart_far_end.got_cnt));
    cts_n <= 1'b0;
    wait_got(1);
    chk("tx1", 8'h5A, i_uart_far_end.got_q);
    wr_reg(OFF_CTL_A, 8'h80);
    cts_n <= 1'b1;
    wr_reg(OFF_DATA, 8'hC3);
    wait_got(2);
    chk("tx2", 8'hC3, i_uart_far_end.got_q);
    repeat (40) @(posedge clk_sys); // let the stop bit finish before mode changes
  endtask
  // receive gating, marker flag, read clear and interrupt
  task automatic t_rx();
    wr_reg(OFF_CTL_A, 8'h00);
    wr_reg(OFF_CTL_B, 8'h20);
    wr_reg(OFF_IRQ_MK, 8'h02);
    i_uart_far_end.send(9'h1A5, 9);
    rd_chk("ev_off", OFF_IRQ_ST, 8'h01); // only tx_done from earlier characters
    wr_reg(OFF_CTL_A, 8'h40);
    i_uart_far_end.send(9'h196, 9);
    chk("irq_rx", 8'h01, {7'h00, irq});
    rd_chk("mark", OFF_STAT_B, 8'h01);
    rd_chk("rxdat", OFF_DATA, 8'h96);
    rd_chk("mark_clr", OFF_STAT_B, 8'h00);
    wr_reg(OFF_IRQ_ST, 8'h02);
    chk("irq_clr", 8'h00, {7'h00, irq});
  endtask
  // parity from the far end, then odd parity and two stops through loopback
  task automatic t_par();
    wr_reg(OFF_CTL_B, 8'h00);
    wr_reg(OFF_CTL_A, 8'h58);
    i_uart_far_end.send(9'h196, 9);
    rd_chk("par_odd", OFF_STAT_A, 8'h02);
    rd_chk("par_dat", OFF_DATA, 8'h96);
    wr_reg(OFF_CTL_A, 8'h50);
    i_uart_far_end.send(9'h196, 9);
    rd_chk("par_even", OFF_STAT_A, 8'h0A);
    wr_reg(OFF_CTL_A, 8'hDB);
    wr_reg(OFF_DATA, 8'h69);
    repeat (182) @(posedge clk_sys); // one stop would be idle here, two still busy
    rd_chk("stop2", OFF_STAT_A, 8'h03);
    repeat (20) @(posedge clk_sys);
    rd_chk("lb_par", OFF_DATA, 8'h69);
  endtask
  // divider timeout only while the port is off
  task automatic t_timeout();
    wr_reg(OFF_IRQ_ST, 8'h07);
    wr_reg(OFF_CTL_B, 8'h40);
    repeat (40) @(posedge clk_sys);
    rd_chk("ev_on", OFF_IRQ_ST, 8'h00);
    wr_reg(OFF_CTL_A, 8'h00);
    repeat (5) @(posedge clk_sys);
    rd_chk("ev_to", OFF_IRQ_ST, 8'h02);
    chk("irq_to", 8'h01, {7'h00, irq});
    wr_reg(OFF_IRQ_MK, 8'h00);
    chk("irq_mk", 8'h00, {7'h00, irq});
    wr_reg(OFF_CTL_B, 8'h00);
  endtask
  // loopback: character reaches receiver, line stays high
  task automatic t_loop();
    wr_reg(OFF_CTL_A, 8'hC1);
    wr_reg(OFF_DATA, 8'h3C);
    repeat (300) @(posedge clk_sys);
    chk("lb_line", 8'h01, {7'h00, txd});
    rd_chk("lb_data", OFF_DATA, 8'h3C);
  endtask
  // break in mid-character drives the line low
  task automatic t_break();
    wr_reg(OFF_CTL_A, 8'h80);
    wr_reg(OFF_DATA, 8'hFF);
    repeat (60) @(posedge clk_sys);
    wr_reg(OFF_CTL_A, 8'h84);
    repeat (4) @(posedge clk_sys);
    chk("break", 8'h00, {7'h00, txd});
    wr_reg(OFF_CTL_A, 8'h80);
    repeat (200) @(posedge clk_sys);
    wr_reg(OFF_DATA, 8'h81);
    repeat (200) @(posedge clk_sys); // character finished before break is set
    chk("sent", 8'h81, i_uart_far_end.got_q);
    wr_reg(OFF_CTL_A, 8'h84);
    repeat (2) @(posedge clk_sys);
    chk("break_idle", 8'h00, {7'h00, txd});
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #1_000_000;
    fails++;
    stop_test();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_tx();
    t_rx();
    t_par();
    t_timeout();
    t_loop();
    t_break();
    stop_test();
  end
endmodule
`default_nettype wire
